// file: design/oam_regs_pkg.sv
// Purpose: shared constants for the maintenance sublayer register slice
// Assumes: 8-bit management register port, one clock, async active-low reset
// Notes: offsets are byte addresses on the management port
// Contract
// - remote address byte replaces frame bits 39:32
// - mode 10 makes byte2 the target address
// - remote data byte replaces frame bits 47:40
// - mode 10 makes byte3 the access data
// - tx counter counts valid sent frames, 0..255
// - rx counter counts good, valid received frames
// - writing zero to clear register zeroes counters
// - mirror follows partner status while link up
// - status bit6 is one on terminal side
// - status bit5 is one in loopback states
// - bit4 notify select: cpu center, pin terminal
// - bit3 diag fail: pin terminal, cpu center
// - bit2 copper down, resets one, side dependent
// - bit1 one when optical signal absent
// - bit0 power-down, inverse of power-down pin
package oam_regs_pkg;
  // ==========================================
  // widths and offsets
  localparam int unsigned REG_W = 8;
  localparam logic [7:0] OFF_REMOTE_ADDR = 8'h4b;
  localparam logic [7:0] OFF_REMOTE_DATA = 8'h4c;
  localparam logic [7:0] OFF_TX_COUNT = 8'h4d;
  localparam logic [7:0] OFF_RX_COUNT = 8'h4e;
  localparam logic [7:0] OFF_MIRROR = 8'h4f;
  localparam logic [7:0] OFF_STATUS = 8'h50;
  localparam logic [7:0] OFF_CNT_CLEAR = 8'h44;
  // ==========================================
  // values
  localparam logic [7:0] CNT_CLEAR_VALUE = 8'h00;
  localparam logic [7:0] REMOTE_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] MIRROR_RST_TERM = 8'h07;
  localparam logic [7:0] MIRROR_RST_CENTER = 8'h47;
  localparam logic [7:0] STATUS_RST = 8'h06;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
  localparam logic [1:0] MODE_EXTENDED = 2'h2;
  // ==========================================
  // status bit positions
  localparam int unsigned ST_SPEED = 7;
  localparam int unsigned ST_ROLE = 6;
  localparam int unsigned ST_LOOP = 5;
  localparam int unsigned ST_NOTIFY = 4;
  localparam int unsigned ST_DIAG = 3;
  localparam int unsigned ST_COPPER = 2;
  localparam int unsigned ST_OPT_ABSENT = 1;
  localparam int unsigned ST_PDN = 0;
endpackage

// file: design/maint_frame_counter.sv
// Purpose: saturating event counter for maintenance frames
// Assumes: event and clear are one-cycle synchronous pulses
// Notes: an event in the clear cycle counts, so it is not lost
`timescale 1ns/1ps
module maint_frame_counter import oam_regs_pkg::*; #(
  parameter int unsigned WIDTH = REG_W
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_event,
  input wire logic i_clear,
  output logic [WIDTH-1:0] o_count
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } cnt_t;

  cnt_t c_q;
  cnt_t c_d;

  if (WIDTH < 1 || WIDTH > REG_W) begin : g_width_check
    $error("counter width must be 1..8");
  end

  // ==========================================
  // next state
  always_comb begin
    c_d = c_q;
    if (i_clear) begin
      c_d.count = i_event ? WIDTH'(1) : '0;
    end else if (i_event && c_q.count != '1) begin
      // stops at all ones rather than wrapping past the top value
      c_d.count = c_q.count + WIDTH'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign o_count = c_q.count;
endmodule

// file: design/remote_cmd_frame_mux.sv
// Purpose: remote command bytes into outgoing maintenance frame fields
// Assumes: model info bytes and mode field come from neighbouring registers
// Notes: outputs settle one clock after their inputs
`timescale 1ns/1ps
module remote_cmd_frame_mux import oam_regs_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_remote_cmd_issue,
  input wire logic [1:0] i_op_mode,
  input wire logic [7:0] i_remote_addr,
  input wire logic [7:0] i_remote_data,
  input wire logic [7:0] i_model_info_2,
  input wire logic [7:0] i_model_info_3,
  output logic [7:0] o_frame_byte_39_32,
  output logic [7:0] o_frame_byte_47_40,
  output logic o_ext_access,
  output logic [7:0] o_ext_addr,
  output logic [7:0] o_ext_data
);
  typedef struct packed {
    logic [7:0] b39;
    logic [7:0] b47;
    logic ext;
    logic [7:0] ea;
    logic [7:0] ed;
  } mux_t;

  mux_t m_q;
  mux_t m_d;

  // ==========================================
  // field selection
  always_comb begin
    m_d = m_q;
    m_d.b39 = i_remote_cmd_issue ? i_remote_addr : i_model_info_2;
    m_d.b47 = i_remote_cmd_issue ? i_remote_data : i_model_info_3;
    m_d.ext = (i_op_mode == MODE_EXTENDED);
    if (i_op_mode == MODE_EXTENDED) begin
      m_d.ea = i_remote_addr;
      m_d.ed = i_remote_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign o_frame_byte_39_32 = m_q.b39;
  assign o_frame_byte_47_40 = m_q.b47;
  assign o_ext_access = m_q.ext;
  assign o_ext_addr = m_q.ea;
  assign o_ext_data = m_q.ed;
endmodule

// file: design/oam_remote_cmd_status_regs.sv
// Purpose: remote command, frame counter, mirror and local status registers
// Assumes: management port strobes are one-cycle, synchronous to i_clk
// Notes: pin-derived reset values are loaded at the first edge after release
`timescale 1ns/1ps
module oam_remote_cmd_status_regs import oam_regs_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_terminal_role,
  input wire logic i_center_loop_state_one,
  input wire logic i_center_loop_state_two,
  input wire logic i_terminal_loop_state_one,
  input wire logic i_link_speed,
  input wire logic i_loss_notify_pin,
  input wire logic i_diag_fail_pin,
  input wire logic i_copper_link_down,
  input wire logic i_optical_signal_absent,
  input wire logic i_powerdown_pin_n,
  input wire logic i_optical_link_up,
  input wire logic [7:0] i_partner_status,
  input wire logic i_tx_frame_sent,
  input wire logic i_rx_frame_valid,
  input wire logic i_remote_cmd_issue,
  input wire logic [1:0] i_op_mode,
  input wire logic [7:0] i_model_info_2,
  input wire logic [7:0] i_model_info_3,
  output logic [7:0] o_reg_rdata,
  output logic [7:0] o_local_status,
  output logic [7:0] o_partner_mirror,
  output logic [7:0] o_tx_count,
  output logic [7:0] o_rx_count,
  output logic [7:0] o_frame_byte_39_32,
  output logic [7:0] o_frame_byte_47_40,
  output logic o_ext_access,
  output logic [7:0] o_ext_addr,
  output logic [7:0] o_ext_data
);
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] mirror;
    logic [7:0] status;
    logic [7:0] rdata;
    logic started;
  } regs_t;

  localparam regs_t REGS_RST = '{
    addr: REMOTE_RST,
    data: REMOTE_RST,
    mirror: MIRROR_RST_TERM,
    status: STATUS_RST,
    rdata: UNMAPPED_RDATA,
    started: 1'b0
  };

  regs_t r_q;
  regs_t r_d;
  logic cnt_clear;
  logic [7:0] tx_count;
  logic [7:0] rx_count;

  // ==========================================
  // counters
  // clear only on a write of the exact clear value; other writes are ignored
  assign cnt_clear = i_reg_wr && i_reg_addr == OFF_CNT_CLEAR && i_reg_wdata == CNT_CLEAR_VALUE;

  maint_frame_counter #(.WIDTH(REG_W)) u_tx_count (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_event(i_tx_frame_sent),
    .i_clear(cnt_clear),
    .o_count(tx_count)
  );

  maint_frame_counter #(.WIDTH(REG_W)) u_rx_count (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_event(i_rx_frame_valid),
    .i_clear(cnt_clear),
    .o_count(rx_count)
  );

  // ==========================================
  // frame field substitution
  remote_cmd_frame_mux u_frame_mux (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_remote_cmd_issue(i_remote_cmd_issue),
    .i_op_mode(i_op_mode),
    .i_remote_addr(r_q.addr),
    .i_remote_data(r_q.data),
    .i_model_info_2(i_model_info_2),
    .i_model_info_3(i_model_info_3),
    .o_frame_byte_39_32(o_frame_byte_39_32),
    .o_frame_byte_47_40(o_frame_byte_47_40),
    .o_ext_access(o_ext_access),
    .o_ext_addr(o_ext_addr),
    .o_ext_data(o_ext_data)
  );

  // ==========================================
  // register next state
  always_comb begin
    r_d = r_q;
    r_d.started = 1'b1;
    if (i_reg_wr && i_reg_addr == OFF_REMOTE_ADDR) begin
      r_d.addr = i_reg_wdata;
    end
    if (i_reg_wr && i_reg_addr == OFF_REMOTE_DATA) begin
      r_d.data = i_reg_wdata;
    end
    // reset value depends on the role strap, so it is taken after release
    if (!r_q.started) begin
      r_d.mirror = i_terminal_role ? MIRROR_RST_TERM : MIRROR_RST_CENTER;
    end else if (i_optical_link_up) begin
      r_d.mirror = i_partner_status;
    end
    r_d.status[ST_SPEED] = i_link_speed;
    r_d.status[ST_ROLE] = i_terminal_role;
    r_d.status[ST_LOOP] = i_center_loop_state_one | i_center_loop_state_two | i_terminal_loop_state_one;
    r_d.status[ST_OPT_ABSENT] = i_optical_signal_absent;
    r_d.status[ST_PDN] = ~i_powerdown_pin_n;
    if (!r_q.started) begin
      r_d.status[ST_DIAG] = i_diag_fail_pin;
    end
    if (i_terminal_role) begin
      r_d.status[ST_NOTIFY] = i_loss_notify_pin;
      r_d.status[ST_DIAG] = i_diag_fail_pin;
      r_d.status[ST_COPPER] = i_copper_link_down;
    end else if (r_q.started && i_reg_wr && i_reg_addr == OFF_STATUS) begin
      r_d.status[ST_NOTIFY] = i_reg_wdata[ST_NOTIFY];
      r_d.status[ST_DIAG] = i_reg_wdata[ST_DIAG];
      r_d.status[ST_COPPER] = i_reg_wdata[ST_COPPER];
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        OFF_REMOTE_ADDR: r_d.rdata = r_q.addr;
        OFF_REMOTE_DATA: r_d.rdata = r_q.data;
        OFF_TX_COUNT: r_d.rdata = tx_count;
        OFF_RX_COUNT: r_d.rdata = rx_count;
        OFF_MIRROR: r_d.rdata = r_q.mirror;
        OFF_STATUS: r_d.rdata = r_q.status;
        default: r_d.rdata = UNMAPPED_RDATA;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_q <= REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_reg_rdata = r_q.rdata;
  assign o_local_status = r_q.status;
  assign o_partner_mirror = r_q.mirror;
  assign o_tx_count = tx_count;
  assign o_rx_count = rx_count;

  // ==========================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  frame_addr_sub_a: assert property (i_remote_cmd_issue |=> o_frame_byte_39_32 == $past(r_q.addr))
    else $error("address byte not placed in frame bits 39:32");
  ext_addr_a: assert property ((i_op_mode == MODE_EXTENDED) |=> o_ext_access && o_ext_addr == $past(r_q.addr))
    else $error("extended mode address byte wrong");
  frame_data_sub_a: assert property (!i_remote_cmd_issue |=> o_frame_byte_47_40 == $past(i_model_info_3))
    else $error("model info byte not used without remote command");
  ext_data_a: assert property ((i_op_mode == MODE_EXTENDED) ##1 (i_op_mode == MODE_EXTENDED)
    |=> o_ext_data == $past(r_q.data))
    else $error("extended mode data byte wrong");
  tx_count_step_a: assert property (i_tx_frame_sent && !cnt_clear && tx_count != 8'hff
    |=> tx_count == 8'($past(tx_count) + 8'h01))
    else $error("tx counter did not step");
  rx_count_step_a: assert property (!i_rx_frame_valid && !cnt_clear |=> $stable(rx_count))
    else $error("rx counter moved without a frame");
  count_clear_a: assert property (cnt_clear && !i_tx_frame_sent && !i_rx_frame_valid
    |=> tx_count == COUNT_RST && rx_count == COUNT_RST)
    else $error("counters not cleared");
  mirror_follow_a: assert property (r_q.started && i_optical_link_up ##1 i_optical_link_up
    |=> o_partner_mirror == $past(i_partner_status))
    else $error("mirror does not follow partner status");
  role_bit_a: assert property (r_q.started |=> o_local_status[ST_ROLE] == $past(i_terminal_role))
    else $error("role bit wrong");
  loop_bit_a: assert property (i_center_loop_state_two |=> o_local_status[ST_LOOP])
    else $error("loopback bit not set");
  notify_bit_a: assert property (i_terminal_role && r_q.started |=> o_local_status[ST_NOTIFY] == $past(i_loss_notify_pin))
    else $error("notify bit does not follow pin");
  diag_bit_a: assert property (!r_q.started |=> o_local_status[ST_DIAG] == $past(i_diag_fail_pin))
    else $error("diag bit not loaded from pin");
  copper_bit_a: assert property (!i_terminal_role && !(i_reg_wr && i_reg_addr == OFF_STATUS) && r_q.started
    |=> $stable(o_local_status[ST_COPPER]))
    else $error("center copper bit changed without a write");
  absent_bit_a: assert property (r_q.started |=> o_local_status[ST_OPT_ABSENT] == $past(i_optical_signal_absent))
    else $error("optical absent bit wrong");
  pdn_bit_a: assert property (r_q.started |=> o_local_status[ST_PDN] != $past(i_powerdown_pin_n))
    else $error("power-down bit wrong");

  remote_cmd_c: cover property (i_op_mode == MODE_EXTENDED ##1 i_remote_cmd_issue);
  count_full_c: cover property (tx_count == 8'hff ##1 cnt_clear);
  center_write_c: cover property (!i_terminal_role && i_reg_wr && i_reg_addr == OFF_STATUS);
endmodule

// file: tb/oam_link_partner_model.sv
// Purpose: far-side stand-in: optical link state, partner status, frame events
// Assumes: bench requests change just after a rising edge
// Notes: status is scrambled while the link is down, so a stale mirror shows
`timescale 1ns/1ps
module oam_link_partner_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_link_req,
  input wire logic [7:0] i_status,
  input wire logic i_tx_go,
  input wire logic i_rx_go,
  output logic o_link_up,
  output logic [7:0] o_partner_status,
  output logic o_tx_sent,
  output logic o_rx_valid
);
  // ==========================================
  // link side
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_link_up <= 1'b0;
      o_partner_status <= 8'h00;
      o_tx_sent <= 1'b0;
      o_rx_valid <= 1'b0;
    end else begin
      o_link_up <= i_link_req;
      // no link, no meaning: flip every cycle rather than hold
      o_partner_status <= i_link_req ? i_status : ~o_partner_status;
      o_tx_sent <= i_tx_go; // one pulse per valid frame sent
      o_rx_valid <= i_rx_go; // one pulse per rx request from the bench, no crc, opcode or direction check
    end
  end
endmodule

// file: tb/tb_oam_remote_cmd_status_regs.sv
// Purpose: self-checking bench for the maintenance register slice
// Assumes: one-cycle strobes, read data one cycle after the read edge
// Notes: each access takes two cycles, so back-to-back strobes are not exercised
`timescale 1ns/1ps
module tb_oam_remote_cmd_status_regs import oam_regs_pkg::*;;
  logic i_clk, i_rstn, i_reg_wr, i_reg_rd, i_terminal_role, i_center_loop_state_one;
  logic i_center_loop_state_two, i_terminal_loop_state_one, i_link_speed, i_loss_notify_pin;
  logic i_diag_fail_pin, i_copper_link_down, i_optical_signal_absent, i_powerdown_pin_n;
  logic i_optical_link_up, i_tx_frame_sent, i_rx_frame_valid, i_remote_cmd_issue, o_ext_access;
  logic link_req, tx_go, rx_go;
  logic [1:0] i_op_mode;
  logic [7:0] i_reg_addr, i_reg_wdata, i_partner_status, i_model_info_2, i_model_info_3;
  logic [7:0] o_reg_rdata, o_local_status, o_partner_mirror, o_tx_count, o_rx_count;
  logic [7:0] o_frame_byte_39_32, o_frame_byte_47_40, o_ext_addr, o_ext_data;
  logic [7:0] pst, rd_v, ra, rdd, cpu, v;
  logic [7:0] rst_exp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h47, 8'h00};
  logic [15:0] lf;
  int mismatches, num_checks, k, nt, nr;

  oam_remote_cmd_status_regs oam_remote_cmd_status_regs_i (
    .i_clk, .i_rstn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_terminal_role,
    .i_center_loop_state_one, .i_center_loop_state_two, .i_terminal_loop_state_one,
    .i_link_speed, .i_loss_notify_pin, .i_diag_fail_pin, .i_copper_link_down,
    .i_optical_signal_absent, .i_powerdown_pin_n, .i_optical_link_up, .i_partner_status,
    .i_tx_frame_sent, .i_rx_frame_valid, .i_remote_cmd_issue, .i_op_mode, .i_model_info_2,
    .i_model_info_3, .o_reg_rdata, .o_local_status, .o_partner_mirror, .o_tx_count,
    .o_rx_count, .o_frame_byte_39_32, .o_frame_byte_47_40, .o_ext_access, .o_ext_addr,
    .o_ext_data
  );
  oam_link_partner_model oam_link_partner_model_i (
    .i_clk, .i_rstn, .i_link_req(link_req), .i_status(pst), .i_tx_go(tx_go),
    .i_rx_go(rx_go), .o_link_up(i_optical_link_up), .o_partner_status(i_partner_status),
    .o_tx_sent(i_tx_frame_sent), .o_rx_valid(i_rx_frame_valid)
  );

  // ==========================================
  // clock and helpers
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  function automatic logic [7:0] exp_st();
    logic [2:0] mid;
    mid = i_terminal_role ? {i_loss_notify_pin, i_diag_fail_pin, i_copper_link_down} : cpu[4:2];
    return {i_link_speed, i_terminal_role,
      i_center_loop_state_one | i_center_loop_state_two | i_terminal_loop_state_one,
      mid, i_optical_signal_absent, ~i_powerdown_pin_n};
  endfunction
  function automatic logic [7:0] sat(int n);
    return (n > 255) ? 8'hff : n[7:0];
  endfunction
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    tick();
    i_reg_wr = 1'b0;
    tick();
  endtask
  task automatic rd(logic [7:0] a);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    tick();
    i_reg_rd = 1'b0;
    rd_v = o_reg_rdata;
    tick();
  endtask
  task automatic rst(logic role);
    i_rstn = 1'b0;
    i_terminal_role = role;
    repeat (3) tick();
    i_rstn = 1'b1;
    repeat (2) tick();
    cpu = {4'h0, i_diag_fail_pin, 3'b100};
  endtask
  task automatic st_loop();
    for (k = 0; k < 12; k++) begin
      v = rnd();
      i_link_speed = v[0];
      {i_center_loop_state_one, i_center_loop_state_two, i_terminal_loop_state_one} = 3'b001 << v[2:1];
      i_loss_notify_pin = v[3];
      i_diag_fail_pin = v[4];
      i_copper_link_down = v[5];
      i_optical_signal_absent = v[6];
      i_powerdown_pin_n = v[7];
      v = rnd();
      wr(OFF_STATUS, v);
      if (!i_terminal_role) cpu[4:2] = v[4:2];
      chk("status", o_local_status, exp_st());
      rd(OFF_STATUS);
      chk("status_rd", rd_v, exp_st());
    end
  endtask
  // tx pulses run back to back when all is set, rx pulses stay random; the count saturates instead of wrapping
  task automatic events(int n, logic all);
    for (int i = 0; i < n; i++) begin
      v = rnd();
      tx_go = v[0] | all;
      rx_go = v[1];
      nt += int'(tx_go);
      nr += int'(rx_go);
      tick();
    end
    tx_go = 1'b0;
    rx_go = 1'b0;
    repeat (2) tick();
    rd(OFF_TX_COUNT);
    chk("tx_cnt", rd_v, sat(nt));
    rd(OFF_RX_COUNT);
    chk("rx_cnt", rd_v, sat(nr));
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    wrap_up();
  end

  // ==========================================
  // main sequence
  initial begin
    lf = 16'h000d;
    mismatches = 0;
    num_checks = 0;
    {i_rstn, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata, i_terminal_role, i_link_speed} = '0;
    {i_center_loop_state_one, i_center_loop_state_two, i_terminal_loop_state_one} = '0;
    {i_loss_notify_pin, i_diag_fail_pin, i_remote_cmd_issue, i_op_mode, link_req, pst} = '0;
    {i_model_info_2, i_model_info_3, tx_go, rx_go} = '0;
    {i_copper_link_down, i_optical_signal_absent, i_powerdown_pin_n} = 3'b111;
    rst(1'b0);
    chk("status_rst", o_local_status, exp_st());
    // read-only and unmapped places take a write and must not change
    for (k = 0; k < 6; k++) begin
      ra = (k == 5) ? 8'h60 : OFF_REMOTE_ADDR + 8'(k);
      if (k > 1) wr(ra, rnd() | 8'h01);
      rd(ra);
      chk("reset_rd", rd_v, rst_exp[k]);
    end
    for (k = 0; k < 8; k++) begin
      ra = rnd();
      rdd = rnd();
      wr(OFF_REMOTE_ADDR, ra);
      wr(OFF_REMOTE_DATA, rdd);
      rd(OFF_REMOTE_ADDR);
      chk("addr_rd", rd_v, ra);
      rd(OFF_REMOTE_DATA);
      chk("data_rd", rd_v, rdd);
      i_model_info_2 = rnd();
      i_model_info_3 = rnd();
      i_remote_cmd_issue = k[0];
      i_op_mode = k[2:1];
      tick();
      chk("f39", o_frame_byte_39_32, k[0] ? ra : i_model_info_2);
      chk("f47", o_frame_byte_47_40, k[0] ? rdd : i_model_info_3);
      chk("ext", {7'h00, o_ext_access}, {7'h00, i_op_mode == MODE_EXTENDED});
      if (i_op_mode == MODE_EXTENDED) begin
        chk("ext_addr", o_ext_addr, ra);
        chk("ext_data", o_ext_data, rdd);
      end
    end
    nt = 0;
    nr = 0;
    events(25, 1'b0);
    wr(OFF_CNT_CLEAR, rnd() | 8'h01);
    chk("no_clr", o_tx_count, sat(nt));
    wr(OFF_CNT_CLEAR, CNT_CLEAR_VALUE);
    nt = 0;
    nr = 0;
    chk("clr", o_rx_count, 8'h00);
    events(270, 1'b1);
    for (k = 0; k < 4; k++) begin
      link_req = 1'b1;
      pst = rnd();
      repeat (2) tick();
      chk("mirror", o_partner_mirror, pst);
    end
    link_req = 1'b0;
    repeat (3) tick();
    rd(OFF_MIRROR);
    chk("mirror_hold", rd_v, pst);
    st_loop();
    rst(1'b1);
    rd(OFF_MIRROR);
    chk("mirror_term", rd_v, MIRROR_RST_TERM);
    chk("status_term", o_local_status, exp_st());
    st_loop();
    wrap_up();
  end
endmodule
